/* File: pwr_seq.sv */
// Chip-level sequencer choosing run, stop, back-up and reset states.
// Assumes supply comparators, reset pin and wake lines are asynchronous;
// CPU sleep, watchdog and key strobe come from logic on clk.
`timescale 1ns/100ps
`include "pwr_seq_defs.svh"
module pwr_seq
	import pwr_seq_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Supply comparators and pin
	input  wire logic        low_voltage_ok,
	input  wire logic        power_on_ok,
	input  wire logic        external_reset_pin,
	// Reset causes from logic
	input  wire logic        watchdog_overflow,
	input  wire logic        key_write,
	input  wire logic [7:0]  software_reset_key,
	// CPU sleep request
	input  wire logic        wait_for_interrupt_instr,
	input  wire logic        wait_for_event_instr,
	input  wire logic        sleep_on_exit,
	input  wire logic        deep_sleep_select,
	// Wake sources
	input  wire wake_src_t   wake_src,
	// Outputs
	output logic             sys_reset,
	output logic             stop_mode,
	output logic             backup_mode,
	output logic             lvd_enable,
	output port_ctl_t        port_ctl
);

	function automatic logic is_debug_pin(input int idx);
		return (idx >= int'(`DEBUG_PIN_LO)) && (idx <= int'(`DEBUG_PIN_HI));
	endfunction : is_debug_pin

	// Two-flop synchronisers for asynchronous inputs
	localparam int SW = 3 + `EXT_INT_LINES + 3;
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {low_voltage_ok, power_on_ok, external_reset_pin, wake_src};
			sync2_q <= sync1_q;
		end
	end
	logic       lv_ok_s;
	logic       por_ok_s;
	logic       pin_s;
	wake_src_t  wake_s;
	assign {lv_ok_s, por_ok_s, pin_s, wake_s} = sync2_q;

	// Edge history
	logic lv_ok_prev_q;
	logic pin_prev_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lv_ok_prev_q <= 1'b0;
			pin_prev_q   <= 1'b0;
		end else begin
			lv_ok_prev_q <= lv_ok_s;
			pin_prev_q   <= pin_s;
		end
	end

	pwr_mode_t mode_q;
	pwr_mode_t mode_d;
	logic      lvd_on;
	assign lvd_on = (mode_q != MODE_STOP);

	logic lv_rise;
	logic pin_rise;
	logic sw_rst;
	logic wdt_rst;
	logic brownout;
	logic any_cause;
	logic sleep_req;
	logic stop_wake;
	assign lv_rise   = lvd_on && lv_ok_s && !lv_ok_prev_q;
	assign pin_rise  = pin_s && !pin_prev_q && lv_ok_s;
	assign sw_rst    = key_write && (software_reset_key == `SW_RESET_KEY);
	assign wdt_rst   = watchdog_overflow && (mode_q != MODE_BACKUP);
	assign brownout  = lvd_on && !lv_ok_s && por_ok_s;
	assign any_cause = lv_rise || pin_rise || sw_rst || wdt_rst || !por_ok_s;
	assign sleep_req = deep_sleep_select
	                && (wait_for_interrupt_instr || wait_for_event_instr || sleep_on_exit);
	assign stop_wake = (|wake_s.ext_int) || wake_s.free_timer_match
	                || wake_s.usb_supply_detect || wake_s.usb_interrupt;

	// Warm-up counter restarts while any cause stands
	logic [`WARMUP_CNT_W-1:0] warm_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			warm_q <= '0;
		end else if (mode_q != MODE_RESET || any_cause) begin
			warm_q <= '0;
		end else if (warm_q != `WARMUP_CNT_W'(`WARMUP_CYCLES)) begin
			warm_q <= warm_q + `WARMUP_CNT_W'(1);
		end
	end

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			MODE_RESET: begin
				if (brownout) begin
					mode_d = MODE_BACKUP;
				end else if (!any_cause && warm_q == `WARMUP_CNT_W'(`WARMUP_CYCLES)) begin
					mode_d = MODE_RUN;
				end
			end
			MODE_RUN: begin
				if (brownout) begin
					mode_d = MODE_BACKUP;
				end else if (any_cause) begin
					mode_d = MODE_RESET;
				end else if (sleep_req) begin
					mode_d = MODE_STOP;
				end
			end
			MODE_STOP: begin
				if (pin_rise || !por_ok_s || sw_rst || wdt_rst) begin
					mode_d = MODE_RESET;
				end else if (stop_wake) begin
					mode_d = lv_ok_s ? MODE_RUN : MODE_BACKUP;
				end
			end
			MODE_BACKUP: begin
				if (!por_ok_s || lv_rise) begin
					mode_d = MODE_RESET;
				end
			end
			default: mode_d = MODE_RESET;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= MODE_RESET;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Registered outputs, from next state so they align with mode_q
	port_ctl_t ctl_d;
	always_comb begin
		ctl_d = port_ctl;
		for (int i = 0; i < `PORT_PINS; i++) begin
			if (mode_d == MODE_BACKUP) begin
				ctl_d.float_pin[i]   = !is_debug_pin(i);
				ctl_d.input_block[i] = !is_debug_pin(i);
				ctl_d.pullup_off[i]  = !is_debug_pin(i);
			end else if (mode_d == MODE_RESET) begin
				ctl_d.float_pin[i]   = !is_debug_pin(i);
				ctl_d.input_block[i] = 1'b0;
				ctl_d.pullup_off[i]  = !is_debug_pin(i);
			end else if (mode_d == MODE_RUN) begin
				ctl_d.float_pin[i]   = 1'b0;
				ctl_d.input_block[i] = 1'b0;
				ctl_d.pullup_off[i]  = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_reset   <= 1'b1;
			stop_mode   <= 1'b0;
			backup_mode <= 1'b0;
			lvd_enable  <= 1'b1;
			port_ctl    <= '1;
		end else begin
			sys_reset   <= (mode_d == MODE_RESET) || (mode_d == MODE_BACKUP);
			stop_mode   <= (mode_d == MODE_STOP);
			backup_mode <= (mode_d == MODE_BACKUP);
			lvd_enable  <= (mode_d != MODE_STOP);
			port_ctl    <= ctl_d;
		end
	end

endmodule : pwr_seq

/* File: pwr_seq_defs.svh */
// Constants of the power, stop and reset sequencer.
// Assumes inclusion by the package and the sequencer module only.
`ifndef PWR_SEQ_DEFS_SVH
`define PWR_SEQ_DEFS_SVH
`define SW_RESET_KEY      8'hA5
`define WARMUP_CYCLES     16
`define WARMUP_CNT_W      5
`define EXT_INT_LINES     12
`define PORT_PINS         50
`define DEBUG_PIN_LO      6'd35
`define DEBUG_PIN_HI      6'd39
`endif

/* File: pwr_seq_pkg.sv */
// Types of the power, stop and reset sequencer.
// Assumes pwr_seq_defs.svh is on the include path.
`include "pwr_seq_defs.svh"
package pwr_seq_pkg;
	typedef enum {MODE_RESET, MODE_RUN, MODE_STOP, MODE_BACKUP} pwr_mode_t;
	typedef struct packed {
		logic [`PORT_PINS-1:0] float_pin;
		logic [`PORT_PINS-1:0] input_block;
		logic [`PORT_PINS-1:0] pullup_off;
	} port_ctl_t;
	typedef struct packed {
		logic                      free_timer_match;
		logic                      usb_supply_detect;
		logic                      usb_interrupt;
		logic [`EXT_INT_LINES-1:0] ext_int;
	} wake_src_t;
endpackage : pwr_seq_pkg

/* File: pwr_seq_sva.sv */
// Checker of sequencer mode and port outputs.
// Assumes a bind to pwr_seq; sees its ports only.
`timescale 1ns/100ps
module pwr_seq_sva
	import pwr_seq_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Causes
	input wire logic       low_voltage_ok,
	input wire logic       power_on_ok,
	input wire logic       key_write,
	input wire logic [7:0] software_reset_key,
	input wire wake_src_t  wake_src,
	// Results
	input wire logic       sys_reset,
	input wire logic       stop_mode,
	input wire logic       backup_mode,
	input wire logic       lvd_enable,
	input wire port_ctl_t  port_ctl
);
	localparam logic [49:0] NON_DBG = 50'h3FF07FFFFFFFF;
	logic [4:0] held_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Cycles spent in reset, saturating
	always_ff @(posedge clk or posedge rst)
		if (rst) held_q <= 5'h0;
		else held_q <= sys_reset ? held_q + {4'h0, held_q != 5'h1F} : 5'h0;
	key_reset_a: assert property (
		!sys_reset && !stop_mode && key_write && software_reset_key == 8'hA5 |=> sys_reset)
		else $error("key reset missed");
	stop_lvd_a: assert property (stop_mode |-> !lvd_enable)
		else $error("detector on in stop");
	stop_hold_a: assert property (stop_mode && $past(stop_mode) |-> $stable(port_ctl))
		else $error("pins moved in stop");
	reset_port_a: assert property (sys_reset && !$past(rst) |->
		port_ctl.float_pin == NON_DBG && port_ctl.pullup_off == NON_DBG)
		else $error("pins wrong in reset");
	backup_port_a: assert property (
		backup_mode |-> port_ctl.input_block == NON_DBG && sys_reset)
		else $error("inputs wrong in back-up");
	warm_up_a: assert property ($fell(sys_reset) |-> held_q >= 5'h10)
		else $error("warm-up too short");
	backup_hold_a: assert property (backup_mode && !low_voltage_ok &&
		!$past(low_voltage_ok) && !$past(low_voltage_ok, 2) && power_on_ok &&
		$past(power_on_ok) && $past(power_on_ok, 2) |=> backup_mode)
		else $error("back-up left early");
	stop_wake_a: assert property (stop_mode && |wake_src |-> ##[1:4] !stop_mode)
		else $error("no wake from stop");
endmodule : pwr_seq_sva
bind pwr_seq pwr_seq_sva u_sva (.*);

/* File: pwr_seq_tb_top.sv */
// Self-checking bench of the power, stop and reset sequencer.
// Assumes the package, the design and its checker compile first.
`timescale 1ns/100ps
module pwr_seq_tb_top
	import pwr_seq_pkg::*;
;
	logic clk, rst, low_voltage_ok, power_on_ok, external_reset_pin, watchdog_overflow;
	logic key_write, wait_for_interrupt_instr, wait_for_event_instr, sleep_on_exit;
	logic deep_sleep_select, sys_reset, stop_mode, backup_mode, lvd_enable;
	logic [7:0] software_reset_key;
	wake_src_t wake_src;
	port_ctl_t port_ctl;
	int num_errors, comparisons, i, j, k;
	pwr_seq DUT (
		.clk                      (clk),
		.rst                      (rst),
		.low_voltage_ok           (low_voltage_ok),
		.power_on_ok              (power_on_ok),
		.external_reset_pin       (external_reset_pin),
		.watchdog_overflow        (watchdog_overflow),
		.key_write                (key_write),
		.software_reset_key       (software_reset_key),
		.wait_for_interrupt_instr (wait_for_interrupt_instr),
		.wait_for_event_instr     (wait_for_event_instr),
		.sleep_on_exit            (sleep_on_exit),
		.deep_sleep_select        (deep_sleep_select),
		.wake_src                 (wake_src),
		.sys_reset                (sys_reset),
		.stop_mode                (stop_mode),
		.backup_mode              (backup_mode),
		.lvd_enable               (lvd_enable),
		.port_ctl                 (port_ctl)
	);
	always #50 clk = ~clk;
	task automatic check(input string what, input logic [149:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	// Waits a bounded time for {reset, stop, back-up}, then compares
	task automatic state(input logic [2:0] e);
		@(negedge clk);
		for (i = 0; i < 60 && {sys_reset, stop_mode, backup_mode} !== e; i++)
			@(negedge clk);
		check("state", {sys_reset, stop_mode, backup_mode}, e);
	endtask : state
	task automatic hit(input int n, input logic v);
		@(posedge clk);
		case (n)
			0: key_write <= v;
			1: watchdog_overflow <= v;
			2: external_reset_pin <= v;
			3: wait_for_interrupt_instr <= v;
			4: wait_for_event_instr <= v;
			5: sleep_on_exit <= v;
			default: wake_src[n-6] <= v;
		endcase
	endtask : hit
	initial begin
		{clk, wake_src, software_reset_key, key_write, watchdog_overflow} = '0;
		{wait_for_interrupt_instr, wait_for_event_instr, sleep_on_exit, deep_sleep_select} = '0;
		{rst, low_voltage_ok, power_on_ok, external_reset_pin} = 4'hF;
		void'($urandom(32'hB513));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		state(3'h0);
		for (j = 0; j < 3; j++) begin
			@(posedge clk) software_reset_key <= 8'hA5 ^ 8'($urandom_range(1, 255));
			hit(0, 1'b1);
			hit(0, 1'b0);
			@(posedge clk) software_reset_key <= 8'hA5;
			@(negedge clk) check("wrong key", sys_reset, 1'b0);
			hit(j, j != 2);
			hit(j, j == 2);
			state(3'h4);
			check("float", port_ctl.float_pin, 50'h3FF07FFFFFFFF);
			state(3'h0);
			check("run pins", port_ctl, '0);
		end
		for (j = 3; j < 6; j++) begin
			@(posedge clk) deep_sleep_select <= 1'b1;
			hit(j, 1'b1);
			hit(j, 1'b0);
			state(3'h2);
			check("lvd off", lvd_enable, 1'b0);
			@(posedge clk) low_voltage_ok <= (j != 3);
			repeat (6) @(negedge clk);
			state(3'h2);
			check("held pins", port_ctl, '0);
			k = 6 + $urandom_range(0, 14);
			hit(k, 1'b1);
			state(j == 3 ? 3'h5 : 3'h0);
			if (j == 3) begin
				hit(1, 1'b1);
				hit(1, 1'b0);
				repeat (4) @(negedge clk);
				state(3'h5);
				check("blocked", port_ctl.input_block, 50'h3FF07FFFFFFFF);
			end
			hit(k, 1'b0);
			@(posedge clk) {low_voltage_ok, deep_sleep_select} <= 2'h2;
			state(3'h0);
		end
		final_report;
	end
	initial begin
		#1000000;
		num_errors++;
		final_report;
	end
endmodule : pwr_seq_tb_top
